/* rsf_reset_source.sv */
// reset-source register: records the last reset cause, holds source enables, forces resets
// assumes rst_n is the power-on reset and sys_reset_req feeds the chip reset tree
// What this block and the software using it do
// RULE_01 - bit 7 write enables clock reset source; read shows clock caused last reset
// RULE_02 - bit 6 read-only flag set when a flash access fault caused reset
// RULE_03 - bit 5 write enables comparator reset; read shows comparator caused reset
// RULE_04 - writing 1 to bit 4 forces reset; bit 4 then reads 1
// RULE_05 - bit 3 read-only flag set when watchdog overflow caused reset
// RULE_06 - bit 2 enables clock-loss detector; reads 1 after its reset
// RULE_07 - bit 1 enables supply monitor; reads 1 after power-on or supply reset
// RULE_08 - bit 0 read-only flag set when the reset pin caused reset
// RULE_09 - software treats other bits as indeterminate when bit 1 reads 1
// RULE_10 - software waits for supply monitor to settle before writing bit 1
// RULE_11 - read-modify-write writes flag bits into the enables, disturbing others; reads here return the flags, not the enables
// RULE_12 - eight-bit register at address 0xef on page 0x0, reset value varies
// RULE_13 - clock-loss detector resets when clock stays stuck over 100 us
// RULE_14 - clock-loss and watchdog sources gated off in suspend and sleep
// RULE_15 - after each reset only the actual cause flag reads 1
module rsf_reset_source
    import rsf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] sfr_page,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // reset event inputs
    input wire logic por_event,
    input wire logic supply_fail,
    input wire logic rtc_event,
    input wire logic comp_event,
    input wire logic wdt_event,
    input wire logic flash_event,
    input wire logic pin_reset_n,
    input wire logic mon_clk,
    input wire logic low_power,
    // outputs
    output logic sys_reset_req,
    output logic supply_monitor_en
);
    rsf_state_t state;
    logic [7:0] flags;
    logic [7:0] next_cause;
    logic [2:0] hold;
    logic en_rtc;
    logic en_cmp;
    logic en_mcd;
    logic pin_sync_a;
    logic pin_sync_b;
    logic mcd_timeout;
    logic hit;
    logic soft_hit;

    assign hit = (sfr_page == RSF_PAGE) && (sfr_addr == RSF_ADDR); // RULE_12
    assign soft_hit = hit && sfr_wr && sfr_wdata[RSF_BIT_SOFT];

    rsf_clock_loss u_clock_loss
    (
        .clk(clk),
        .rst_n(rst_n),
        .mon_clk(mon_clk),
        .enable(en_mcd && !low_power), // RULE_14
        .timeout(mcd_timeout)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync_a <= 1'b1;
            pin_sync_b <= 1'b1;
        end
        else
        begin
            pin_sync_a <= pin_reset_n;
            pin_sync_b <= pin_sync_a;
        end
    end

    // one cause is chosen by priority so only one flag is recorded
    always_comb
    begin
        next_cause = 8'h00;
        if (por_event || (supply_fail && supply_monitor_en))
            next_cause[RSF_BIT_POR] = 1'b1; // RULE_07
        else if (!pin_sync_b)
            next_cause[RSF_BIT_PIN] = 1'b1; // RULE_08
        else if (mcd_timeout)
            next_cause[RSF_BIT_MCD] = 1'b1; // RULE_06
        else if (wdt_event && !low_power)
            next_cause[RSF_BIT_WDT] = 1'b1; // RULE_05 RULE_14
        else if (flash_event)
            next_cause[RSF_BIT_FLASH] = 1'b1; // RULE_02
        else if (comp_event && en_cmp)
            next_cause[RSF_BIT_CMP] = 1'b1; // RULE_03
        else if (rtc_event && en_rtc)
            next_cause[RSF_BIT_RTC] = 1'b1; // RULE_01
        else if (soft_hit)
            next_cause[RSF_BIT_SOFT] = 1'b1; // RULE_04
    end

    // reset request sequencing and cause capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= RSF_ST_RUN;
            flags <= RSF_FLAGS_POR;
            hold <= 3'h0;
            sys_reset_req <= 1'b0;
        end
        else
        begin
            case (state)
                RSF_ST_RUN:
                begin
                    if (next_cause != 8'h00)
                    begin
                        state <= RSF_ST_RESET;
                        flags <= next_cause; // RULE_15
                        hold <= 3'h0;
                        sys_reset_req <= 1'b1;
                    end
                end
                RSF_ST_RESET:
                begin
                    if (hold == RSF_HOLD_LAST && pin_sync_b)
                    begin
                        state <= RSF_ST_RUN;
                        sys_reset_req <= 1'b0;
                    end
                    else if (hold != RSF_HOLD_LAST)
                    begin
                        hold <= hold + 3'h1;
                    end
                end
                default:
                begin
                    state <= RSF_ST_RUN;
                    sys_reset_req <= 1'b0;
                end
            endcase
        end
    end

    // enables live apart from flags; reads return only flags, so read-modify-write writes flag bits into the enables
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_rtc <= RSF_EN_RTC_RST;
            en_cmp <= RSF_EN_CMP_RST;
            en_mcd <= RSF_EN_MCD_RST;
            supply_monitor_en <= RSF_EN_VDD_RST;
        end
        else if (hit && sfr_wr && state == RSF_ST_RUN) // RULE_11
        begin
            en_rtc <= sfr_wdata[RSF_BIT_RTC]; // RULE_01
            en_cmp <= sfr_wdata[RSF_BIT_CMP]; // RULE_03
            en_mcd <= sfr_wdata[RSF_BIT_MCD]; // RULE_06
            supply_monitor_en <= sfr_wdata[RSF_BIT_POR]; // RULE_07
        end
    end

    // read path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (hit && sfr_rd)
            sfr_rdata <= flags; // RULE_12
        else
            sfr_rdata <= 8'h00;
    end

    property p_soft_force;
        @(posedge clk) disable iff (!rst_n)
        (state == RSF_ST_RUN && soft_hit && next_cause == 8'h10) |=> sys_reset_req && flags == 8'h10;
    endproperty
    a_soft_force: assert property (p_soft_force) // RULE_04
        else $error("software reset not forced or not flagged");

    property p_flags_hold;
        @(posedge clk) disable iff (!rst_n)
        (state == RSF_ST_RUN && next_cause == 8'h00) |=> $stable(flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) // RULE_02
        else $error("flag changed without a reset cause");

    property p_one_cause;
        @(posedge clk) disable iff (!rst_n)
        $onehot(flags);
    endproperty
    a_one_cause: assert property (p_one_cause) // RULE_15
        else $error("more than one cause flag set");

    property p_wdt_sleep;
        @(posedge clk) disable iff (!rst_n)
        (state == RSF_ST_RUN && low_power && wdt_event) |=> !(sys_reset_req && flags[RSF_BIT_WDT]);
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) // RULE_14
        else $error("watchdog reset taken in low power");

    property p_cmp_enable;
        @(posedge clk) disable iff (!rst_n)
        (hit && sfr_wr && state == RSF_ST_RUN) |=> en_cmp == $past(sfr_wdata[RSF_BIT_CMP]);
    endproperty
    a_cmp_enable: assert property (p_cmp_enable) // RULE_03
        else $error("comparator enable not written");

    property p_read_back;
        @(posedge clk) disable iff (!rst_n)
        (hit && sfr_rd) |=> sfr_rdata == $past(flags);
    endproperty
    a_read_back: assert property (p_read_back) // RULE_12
        else $error("read data does not match flags");

    property p_hold_len;
        @(posedge clk) disable iff (!rst_n)
        $rose(sys_reset_req) |-> sys_reset_req [*5];
    endproperty
    a_hold_len: assert property (p_hold_len) // RULE_15
        else $error("reset request too short");

    property p_pin_flag;
        @(posedge clk) disable iff (!rst_n)
        (state == RSF_ST_RUN && !pin_sync_b && !por_event && !(supply_fail && supply_monitor_en))
        |=> flags == 8'h01;
    endproperty
    a_pin_flag: assert property (p_pin_flag) // RULE_08
        else $error("pin reset not flagged");

    property p_supply_gate;
        @(posedge clk) disable iff (!rst_n)
        (state == RSF_ST_RUN && supply_fail && supply_monitor_en) |=> flags == 8'h02 && sys_reset_req;
    endproperty
    a_supply_gate: assert property (p_supply_gate) // RULE_07
        else $error("supply reset not taken");
endmodule

/* rsf_pkg.sv */
// constants shared by the reset-source register block
// assumes a 10 MHz system clock and an 8-bit special-function register port
package rsf_pkg;
    // register location
    localparam logic [7:0] RSF_ADDR = 8'hef;
    localparam logic [7:0] RSF_PAGE = 8'h00;
    // bit positions
    localparam int RSF_BIT_RTC = 7;
    localparam int RSF_BIT_FLASH = 6;
    localparam int RSF_BIT_CMP = 5;
    localparam int RSF_BIT_SOFT = 4;
    localparam int RSF_BIT_WDT = 3;
    localparam int RSF_BIT_MCD = 2;
    localparam int RSF_BIT_POR = 1;
    localparam int RSF_BIT_PIN = 0;
    // values after power-on
    localparam logic [7:0] RSF_FLAGS_POR = 8'h02;
    localparam logic RSF_EN_RTC_RST = 1'b0;
    localparam logic RSF_EN_CMP_RST = 1'b0;
    localparam logic RSF_EN_MCD_RST = 1'b0;
    localparam logic RSF_EN_VDD_RST = 1'b1;
    // timing
    localparam int RSF_CLK_PERIOD_NS = 100;
    localparam int RSF_MCD_TIMEOUT_US = 100;
    localparam int RSF_MCD_CYCLES = (RSF_MCD_TIMEOUT_US * 1000) / RSF_CLK_PERIOD_NS;
    localparam logic [9:0] RSF_MCD_LAST = 10'(RSF_MCD_CYCLES - 1);
    localparam logic [2:0] RSF_HOLD_LAST = 3'h4;
    // reset request state
    typedef enum logic [0:0]
    {
        RSF_ST_RUN = 1'b0,
        RSF_ST_RESET = 1'b1
    } rsf_state_t;
endpackage

/* rsf_clock_loss.sv */
// clock-loss detector: times out when the watched clock stops toggling
// assumes mon_clk is asynchronous to clk and toggles far faster than the timeout
module rsf_clock_loss
    import rsf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched clock and control
    input wire logic mon_clk,
    input wire logic enable,
    // result
    output logic timeout
);
    logic sync_a;
    logic sync_b;
    logic prev_b;
    logic [9:0] count;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev_b <= 1'b0;
        end
        else
        begin
            sync_a <= mon_clk;
            sync_b <= sync_a;
            prev_b <= sync_b;
        end
    end

    // stuck high or low past the timeout raises a one-cycle pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 10'h000;
            timeout <= 1'b0;
        end
        else if (!enable || (sync_b != prev_b))
        begin
            count <= 10'h000;
            timeout <= 1'b0;
        end
        else if (count == RSF_MCD_LAST) // RULE_13
        begin
            count <= 10'h000;
            timeout <= 1'b1;
        end
        else
        begin
            count <= count + 10'h001;
            timeout <= 1'b0;
        end
    end

    property p_mcd_off;
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !timeout;
    endproperty
    a_mcd_off: assert property (p_mcd_off) // RULE_13
        else $error("clock-loss timeout while detector disabled");
endmodule

/* rsf_src_model.sv */
// partner model: on-chip reset detectors, reset pin and the watched clock
// assumes bench requests change just after the rising edge of clk
module rsf_src_model
(
    // requests from bench
    input wire logic [5:0] req,
    input wire logic stop_clk,
    input wire logic pin_low,
    // detector outputs
    output logic [5:0] ev,
    output logic mon_clk,
    output logic pin_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // each detector raises its event for as long as the bench asks
    assign ev = req;
    assign pin_reset_n = ~pin_low;
    // watched clock stops while stop_clk is high
    initial
    begin
        mon_clk = 1'b0;
        forever #37 mon_clk = stop_clk ? mon_clk : ~mon_clk;
    end
endmodule

/* rsf_reset_source_tb_top.sv */
// testbench for the reset-source register: events, writes and reads against a model
// assumes rsf_pkg and rsf_src_model are compiled first
module rsf_reset_source_tb_top;
    import rsf_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, sfr_wr, sfr_rd, stop_clk, pin_low, low_power, sys_reset_req, supply_monitor_en;
    logic mon_clk, pin_reset_n;
    logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata, lfsr, en, flags;
    logic [5:0] req, ev;
    int num_errors, check_count, cyc;
    rsf_src_model src (.req(req), .stop_clk(stop_clk), .pin_low(pin_low), .ev(ev), .mon_clk(mon_clk),
        .pin_reset_n(pin_reset_n));
    rsf_reset_source dut (.clk(clk), .rst_n(rst_n), .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .por_event(ev[5]), .supply_fail(ev[4]),
        .rtc_event(ev[0]), .comp_event(ev[1]), .wdt_event(ev[2]), .flash_event(ev[3]),
        .pin_reset_n(pin_reset_n), .mon_clk(mon_clk), .low_power(low_power),
        .sys_reset_req(sys_reset_req), .supply_monitor_en(supply_monitor_en));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_page <= p;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge clk);
        sfr_page <= RSF_PAGE;
        sfr_addr <= RSF_ADDR;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 chk("flags", sfr_rdata, exp);
    endtask
    task automatic wait_reset(input logic [7:0] cause);
        int n;
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 1100)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("reset request", {7'h00, sys_reset_req}, 8'h01);
        while (sys_reset_req === 1'b1 && n < 1200)
        begin
            @(posedge clk);
            #1 n++;
        end
        flags = cause;
    endtask
    task automatic no_reset();
        repeat (6)
        begin
            @(posedge clk);
            #1 chk("no reset", {7'h00, sys_reset_req}, 8'h00);
        end
    endtask
    function automatic logic [7:0] exp_of(input int k);
        case (k)
            0: return en[7] ? 8'h80 : 8'h00;
            1: return en[5] ? 8'h20 : 8'h00;
            2: return low_power ? 8'h00 : 8'h08;
            3: return 8'h40;
            4: return en[1] ? 8'h02 : 8'h00;
            default: return 8'h02;
        endcase
    endfunction
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic fire(input int k);
        @(posedge clk);
        req <= 6'h01 << k;
        @(posedge clk);
        req <= 6'h00;
        if (exp_of(k) != 8'h00)
            wait_reset(exp_of(k));
        else
            no_reset();
        rd(flags);
    endtask
    initial
    begin
        {rst_n, sfr_wr, sfr_rd, stop_clk, pin_low, low_power, req, cyc} = '0;
        {sfr_page, sfr_wdata, num_errors, check_count} = '0;
        sfr_addr = RSF_ADDR;
        lfsr = 8'h27;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h02);
        chk("supply enable", {7'h00, supply_monitor_en}, 8'h01);
        en = 8'h00;
        flags = 8'h02;
        wr(RSF_PAGE, RSF_ADDR, 8'h49);
        rd(flags);
        chk("supply enable", {7'h00, supply_monitor_en}, 8'h00);
        for (int k = 0; k < 6; k++)
            fire(k);
        $display("end of disabled sources");
        repeat (8)
        begin
            lfsr = lfsr_next(lfsr);
            wr(RSF_PAGE, (lfsr == RSF_ADDR) ? 8'hee : lfsr, 8'h10);
            wr(lfsr | 8'h01, RSF_ADDR, 8'h10);
            no_reset();
        end
        $display("end of unmapped writes");
        en = 8'ha6;
        wr(RSF_PAGE, RSF_ADDR, en);
        #1 chk("supply enable", {7'h00, supply_monitor_en}, 8'h01);
        @(posedge clk) low_power <= 1'b1;
        fire(2);
        @(posedge clk) low_power <= 1'b0;
        for (int k = 0; k < 6; k++)
            fire(k);
        @(posedge clk) pin_low <= 1'b1;
        repeat (4) @(posedge clk);
        pin_low <= 1'b0;
        wait_reset(8'h01);
        rd(flags);
        wr(RSF_PAGE, RSF_ADDR, en | 8'h10);
        wait_reset(8'h10);
        rd(flags);
        @(posedge clk) stop_clk <= 1'b1;
        wait_reset(8'h04);
        @(posedge clk) stop_clk <= 1'b0;
        rd(flags);
        @(posedge clk) low_power <= 1'b1;
        @(posedge clk) stop_clk <= 1'b1;
        repeat (176) no_reset();
        stop_clk <= 1'b0;
        repeat (4) @(posedge clk);
        low_power <= 1'b0;
        $display("end of enabled sources");
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h02);
        $display("end of second power-on");
        close_out();
    end
endmodule
